// ### src/gpio_wake_pkg.sv
// Constants, register map and carrier types for the LED, GPIO and wake block
// Contract
// [R1] Enabled wake event asserts the wake indicator
// [R2] Software picks wake polarity and output drive type
// [R3] Wake event alone never ends power saving
// [R4] Host write strobes end power saving
// [R5] Host wakes device via byte-order test register; the code ends sleep on any host write strobe and decodes no address
// [R6] Speed strap sampled at reset release, held
// [R7] Each pin: push-pull, open-drain or input
// [R8] Pins selectable as status LED outputs
// [R9] LED pins always driven open-drain
// [R10] Speed LED high only at 10 Mb/s
// [R11] Link LED low while link valid
// [R12] Activity pulses link LED high 80 ms
// [R13] Then low at least 80 ms, repeat
// [R14] Duplex LED low in full duplex
// [R15] LED and wake timing run from reference clock
// [R16] Blink counter on clock, cleared by reset
// [R17] Wake indicator holds until cleared or disabled
package gpio_wake_pkg;
	// Clock and blink timing
	localparam int CLK_PERIOD_NS  = 8;             // MCLK period
	localparam int BLINK_TIME_MS  = 80;            // LED off and on-hold time
	localparam int BLINK_CYCLES   = (BLINK_TIME_MS * 1_000_000) / CLK_PERIOD_NS;
	localparam int NUM_PINS       = 3;             // General-purpose pins

	// Register byte offsets
	localparam logic [7:0] PIN_CFG_ADDR   = 8'h00;  // Direction, drive type, LED select
	localparam logic [7:0] PIN_DATA_ADDR  = 8'h04;  // Output data / pin levels
	localparam logic [7:0] WAKE_CTRL_ADDR = 8'h08;  // Wake enable, polarity, drive
	localparam logic [7:0] STATUS_ADDR    = 8'h0C;  // Event, sleep, strap status

	// Pin configuration field positions
	localparam int CFG_DIR_LSB  = 0;   // 1 = output
	localparam int CFG_OD_LSB   = 4;   // 1 = open-drain
	localparam int CFG_LED_LSB  = 8;   // 1 = LED function

	// Wake control field positions
	localparam int WC_ENABLE    = 0;   // Wake indicator enabled
	localparam int WC_POL_HIGH  = 1;   // 1 = active high
	localparam int WC_PUSHPULL  = 2;   // 1 = push-pull, 0 = open-drain
	localparam int WC_SLEEP     = 3;   // Write 1 enters power saving

	// Status field positions
	localparam int ST_EVENT     = 0;   // Sticky wake event, write 1 clears
	localparam int ST_SLEEP     = 1;   // Power saving active
	localparam int ST_STRAP     = 2;   // Latched speed strap

	// Reset values
	localparam logic [2:0] PIN_RESET_VALUE = 3'h0;
	localparam logic [2:0] WAKE_CTRL_RESET = 3'h0;

	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;

	// Link/activity LED blink states
	typedef enum logic [1:0] {
		BLINK_SOLID = 2'b00,   // Following link only
		BLINK_OFF   = 2'b01,   // LED forced off
		BLINK_HOLD  = 2'b10    // LED follows link, no new off pulse for minimum time
	} blink_state_t;

	// Status inputs from the link
	typedef struct packed {
		logic link_up;         // Valid link
		logic speed_10;        // Operating at 10 Mb/s
		logic autoneg;         // Auto-negotiation in progress
		logic full_duplex;     // Full-duplex link
		logic activity;        // Transmit or receive activity pulse
	} link_status_t;

	// Two-signal pin group
	typedef struct packed {
		logic [NUM_PINS-1:0] out;  // Output level
		logic [NUM_PINS-1:0] oe;   // Output enable
	} pin_drive_t;
endpackage

// ### src/led_gpio_wake_indicator.sv
// GPIO/LED pin multiplexing, activity blink, wake indicator and sleep exit
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module led_gpio_wake_indicator #(
	parameter int BLINK_CYCLES = gpio_wake_pkg::BLINK_CYCLES  // 80 ms in MCLK cycles
) (
	input  wire logic                 MCLK,            // 125 MHz clock
	input  wire logic                 RST_N,           // Synchronous reset, active low
	input  wire logic                 HSEL,            // AHB slave select
	input  wire logic [7:0]           HADDR,           // AHB address
	input  wire logic [1:0]           HTRANS,          // AHB transfer type
	input  wire logic                 HWRITE,          // AHB write
	input  wire logic [2:0]           HSIZE,           // AHB size
	input  wire logic [31:0]          HWDATA,          // AHB write data
	input  wire logic                 HREADY,          // AHB bus ready
	output logic      [31:0]          HRDATA,          // AHB read data
	output logic                      HREADYOUT,       // AHB slave ready
	output logic                      HRESP,           // AHB response, always OKAY
	input  wire gpio_wake_pkg::link_status_t LINK,     // Link status from PHY
	input  wire logic                 WAKE_EVENT,      // Wake event detected pulse
	input  wire logic                 HOST_SELECT_N,   // Host chip select, low active
	input  wire logic                 HOST_WRITE_N,    // Host write strobe, low active
	input  wire logic                 SPEED_SEL,       // Speed strap input
	input  wire logic [2:0]           GPIO_IN,         // Pin input levels
	output gpio_wake_pkg::pin_drive_t GPIO_DRIVE,      // Pin output and enable
	output logic                      WAKE_OUT,        // Wake indicator level
	output logic                      WAKE_OE,         // Wake indicator enable
	output logic                      SLEEPING,        // Power saving active
	output logic                      SPEED_DEFAULT    // Latched default speed
);
	localparam int CW = 24;  // Blink counter width

	// Refuse blink times that the counter cannot hold or that are shorter than two cycles
	if (BLINK_CYCLES < 2 || BLINK_CYCLES >= (1 << CW)) begin
		$error("BLINK_CYCLES out of range");
	end

	// Whole module state
	typedef struct packed {
		logic [2:0]                dir;        // Output direction per pin
		logic [2:0]                od;         // Open-drain per pin
		logic [2:0]                led;        // LED function per pin
		logic [2:0]                data;       // GPIO output data
		logic [2:0]                wctrl;      // Enable, polarity, push-pull
		logic                      event_flag; // Sticky wake event
		logic                      sleep;      // Power saving
		logic                      strap;      // Latched speed strap
		logic                      strap_done; // Strap already taken
		gpio_wake_pkg::blink_state_t bstate;   // Activity blink state
		logic [CW-1:0]             bcount;     // Blink interval counter
		logic                      pend;       // Activity seen during hold
		logic                      wr_pend;    // Write data phase pending
		logic [7:0]                wr_addr;    // Write address latched
		logic [31:0]               rdata;      // Read data register
		gpio_wake_pkg::pin_drive_t drive;      // Pin drive register
		logic                      wout;       // Wake output level
		logic                      woe;        // Wake output enable
	} state_t;

	state_t st;        // Current state
	state_t next_st;   // Next state

	logic addr_phase;  // Valid address phase this cycle
	logic wake_on;     // Wake indicator asserted
	logic level_high;  // Wake pin electrical level
	logic speed_led_n;         // Speed LED level
	logic link_activity_led_n; // Link/activity LED level
	logic duplex_led_n;        // Duplex LED level
	logic [2:0] led_n; // LED levels by pin
	logic host_write;  // Host write cycle seen
	logic clr_event;   // Software clears event

	// Next-state logic for the whole block
	always_comb begin
		next_st    = st;
		addr_phase = HSEL && HREADY && (HTRANS == gpio_wake_pkg::HTRANS_NONSEQ
			|| HTRANS == gpio_wake_pkg::HTRANS_SEQ);
		host_write = !HOST_SELECT_N && !HOST_WRITE_N;
		clr_event  = 1'b0;

		// Register writes land in the data phase
		next_st.wr_pend = addr_phase && HWRITE;
		next_st.wr_addr = HADDR;
		if (st.wr_pend) begin
			unique case (st.wr_addr)
				gpio_wake_pkg::PIN_CFG_ADDR: begin
					next_st.dir = HWDATA[gpio_wake_pkg::CFG_DIR_LSB +: 3];  // R7
					next_st.od  = HWDATA[gpio_wake_pkg::CFG_OD_LSB +: 3];   // R7
					next_st.led = HWDATA[gpio_wake_pkg::CFG_LED_LSB +: 3];  // R8
				end
				gpio_wake_pkg::PIN_DATA_ADDR: begin
					next_st.data = HWDATA[2:0];
				end
				gpio_wake_pkg::WAKE_CTRL_ADDR: begin
					next_st.wctrl = HWDATA[2:0];  // R2
					if (HWDATA[gpio_wake_pkg::WC_SLEEP])
						next_st.sleep = 1'b1;
				end
				gpio_wake_pkg::STATUS_ADDR: begin
					clr_event = HWDATA[gpio_wake_pkg::ST_EVENT];
				end
				default: begin
					// Unmapped writes are dropped
				end
			endcase
		end

		// Sticky event; a new event wins over the clear
		if (WAKE_EVENT)
			next_st.event_flag = 1'b1;  // R1
		else if (clr_event)
			next_st.event_flag = 1'b0;  // R17

		// Only a host write strobe ends sleep; the wake event does not
		if (host_write)
			next_st.sleep = 1'b0;  // R3 R4

		// Strap caught on the first edge after reset release
		if (!st.strap_done) begin
			next_st.strap      = SPEED_SEL;  // R6
			next_st.strap_done = 1'b1;
		end

		// Read data captured in the address phase
		next_st.rdata = 32'h0000_0000;
		if (addr_phase && !HWRITE) begin
			unique case (HADDR)
				gpio_wake_pkg::PIN_CFG_ADDR:
					next_st.rdata = {21'h00_0000, st.led, 1'b0, st.od, 1'b0, st.dir};
				gpio_wake_pkg::PIN_DATA_ADDR:
					next_st.rdata = {29'h0000_0000, GPIO_IN};
				gpio_wake_pkg::WAKE_CTRL_ADDR:
					next_st.rdata = {29'h0000_0000, st.wctrl};
				gpio_wake_pkg::STATUS_ADDR:
					next_st.rdata = {29'h0000_0000, st.strap, st.sleep, st.event_flag};
				default:
					next_st.rdata = 32'h0000_0000;
			endcase
		end

		// Activity blink timing from one counter
		unique case (st.bstate)
			gpio_wake_pkg::BLINK_SOLID: begin
				next_st.bcount = '0;
				if (LINK.link_up && LINK.activity)
					next_st.bstate = gpio_wake_pkg::BLINK_OFF;  // R12
			end
			gpio_wake_pkg::BLINK_OFF: begin
				next_st.bcount = st.bcount + 1'b1;  // R16
				if (st.bcount == CW'(BLINK_CYCLES - 1)) begin
					next_st.bcount = '0;
					next_st.pend   = 1'b0;
					next_st.bstate = gpio_wake_pkg::BLINK_HOLD;  // R13
				end
			end
			gpio_wake_pkg::BLINK_HOLD: begin
				next_st.bcount = st.bcount + 1'b1;  // R16
				if (LINK.activity)
					next_st.pend = 1'b1;
				if (st.bcount == CW'(BLINK_CYCLES - 1)) begin
					next_st.bcount = '0;
					next_st.pend   = 1'b0;
					// Activity during the hold starts another pulse
					next_st.bstate = (st.pend || LINK.activity) && LINK.link_up
						? gpio_wake_pkg::BLINK_OFF : gpio_wake_pkg::BLINK_SOLID;  // R13
				end
			end
			default: begin
				next_st.bstate = gpio_wake_pkg::BLINK_SOLID;
				next_st.bcount = '0;
			end
		endcase

		// LED levels
		speed_led_n         = LINK.link_up && LINK.speed_10 && !LINK.autoneg;  // R10
		link_activity_led_n = !LINK.link_up
			|| (st.bstate == gpio_wake_pkg::BLINK_OFF);  // R11 R12
		duplex_led_n        = !(LINK.link_up && LINK.full_duplex);  // R14
		led_n               = {duplex_led_n, link_activity_led_n, speed_led_n};

		// Pin drive per pin; LED use forces open-drain
		for (int i = 0; i < 3; i++) begin
			if (st.led[i]) begin
				next_st.drive.out[i] = 1'b0;       // R9
				next_st.drive.oe[i]  = !led_n[i];  // R9
			end else if (!st.dir[i]) begin
				next_st.drive.out[i] = 1'b0;       // R7
				next_st.drive.oe[i]  = 1'b0;
			end else if (st.od[i]) begin
				next_st.drive.out[i] = 1'b0;       // R7
				next_st.drive.oe[i]  = !st.data[i];
			end else begin
				next_st.drive.out[i] = st.data[i]; // R7
				next_st.drive.oe[i]  = 1'b1;
			end
		end

		// Wake indicator with chosen polarity and drive type
		wake_on    = st.wctrl[gpio_wake_pkg::WC_ENABLE] && st.event_flag;  // R1 R17
		level_high = wake_on == st.wctrl[gpio_wake_pkg::WC_POL_HIGH];  // R2
		if (st.wctrl[gpio_wake_pkg::WC_PUSHPULL]) begin
			next_st.wout = level_high;  // R2
			next_st.woe  = 1'b1;
		end else begin
			next_st.wout = 1'b0;  // R2
			next_st.woe  = !level_high;
		end
	end

	// State register; counter and all control cleared by reset
	always_ff @(posedge MCLK) begin  // R15
		if (!RST_N) begin
			st        <= '0;  // R16
			st.dir    <= gpio_wake_pkg::PIN_RESET_VALUE;
			st.wctrl  <= gpio_wake_pkg::WAKE_CTRL_RESET;
			st.bstate <= gpio_wake_pkg::BLINK_SOLID;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state flip-flops; ready and response are constants
	assign HRDATA        = st.rdata;
	assign HREADYOUT     = 1'b1;  // Zero wait states
	assign HRESP         = 1'b0;  // Always OKAY
	assign GPIO_DRIVE    = st.drive;
	assign WAKE_OUT      = st.wout;
	assign WAKE_OE       = st.woe;
	assign SLEEPING      = st.sleep;
	assign SPEED_DEFAULT = st.strap;

	// Wake event turns on an enabled indicator two edges later
	wake_assert_a: assert property (@(posedge MCLK) disable iff (!RST_N) // R1
		WAKE_EVENT && st.wctrl[0] && $stable(st.wctrl) ##1 $stable(st.wctrl)
		|=> ($past(st.wctrl[2]) ? WAKE_OE && WAKE_OUT == $past(st.wctrl[1])
			: WAKE_OE != $past(st.wctrl[1]) && !WAKE_OUT))
		else $error("wake indicator not asserted");

	// A push-pull GPIO output always drives its data
	gpio_pp_a: assert property (@(posedge MCLK) disable iff (!RST_N) // R7
		((GPIO_DRIVE.oe & $past(st.dir & ~st.od & ~st.led))
			== $past(st.dir & ~st.od & ~st.led))
		&& (((GPIO_DRIVE.out ^ $past(st.data)) & $past(st.dir & ~st.od & ~st.led)) == 3'h0))
		else $error("push-pull pin not driving its data");

	// Speed LED released only at 10 Mb/s with negotiation done
	speed_led_a: assert property (@(posedge MCLK) disable iff (!RST_N) // R10
		$past(st.led[0])
		|-> GPIO_DRIVE.oe[0] != ($past(LINK.link_up) && $past(LINK.speed_10)
			&& !$past(LINK.autoneg)))
		else $error("speed LED level wrong");

	// Link LED lit while the link is valid and no off pulse runs
	link_led_a: assert property (@(posedge MCLK) disable iff (!RST_N) // R11
		$past(st.led[1]) && $past(st.bstate) != gpio_wake_pkg::BLINK_OFF
		|-> GPIO_DRIVE.oe[1] == $past(LINK.link_up))
		else $error("link LED level wrong");

	// Duplex LED lit only on a full-duplex link
	duplex_led_a: assert property (@(posedge MCLK) disable iff (!RST_N) // R14
		$past(st.led[2])
		|-> GPIO_DRIVE.oe[2] == ($past(LINK.link_up) && $past(LINK.full_duplex)))
		else $error("duplex LED level wrong");

	// Push-pull always drives
	wake_drive_a: assert property (@(posedge MCLK) disable iff (!RST_N) // R2
		st.wctrl[2] && $past(st.wctrl[2]) |-> WAKE_OE)
		else $error("push-pull wake pin not driven");

	// Wake event never clears sleep
	sleep_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N) // R3
		st.sleep && !(!HOST_SELECT_N && !HOST_WRITE_N) |=> st.sleep)
		else $error("sleep left without host write");

	// Host write cycle ends sleep
	sleep_exit_a: assert property (@(posedge MCLK) disable iff (!RST_N) // R4
		!HOST_SELECT_N && !HOST_WRITE_N |=> !SLEEPING)
		else $error("host write did not end sleep");

	// Strap holds after capture
	strap_keep_a: assert property (@(posedge MCLK) disable iff (!RST_N) // R6
		st.strap_done && $past(st.strap_done) |-> $stable(SPEED_DEFAULT))
		else $error("strap value changed");

	// LED pin 0 never drives high
	led_od_a: assert property (@(posedge MCLK) disable iff (!RST_N) // R9
		$past(st.led[0]) && st.led[0] |-> !(GPIO_DRIVE.oe[0] && GPIO_DRIVE.out[0]))
		else $error("LED pin driven high");

	// Off pulse lasts the blink time, then hold
	blink_len_a: assert property (@(posedge MCLK) disable iff (!RST_N) // R12
		st.bstate == gpio_wake_pkg::BLINK_OFF && st.bcount == CW'(BLINK_CYCLES - 1)
		|=> st.bstate == gpio_wake_pkg::BLINK_HOLD && st.bcount == '0)
		else $error("off pulse length wrong");

	// Hold never ends early
	hold_min_a: assert property (@(posedge MCLK) disable iff (!RST_N) // R13
		st.bstate == gpio_wake_pkg::BLINK_HOLD && st.bcount < CW'(BLINK_CYCLES - 1)
		|=> st.bstate == gpio_wake_pkg::BLINK_HOLD)
		else $error("on-hold cut short");

	// Event flag stays until cleared
	event_keep_a: assert property (@(posedge MCLK) disable iff (!RST_N) // R17
		st.event_flag && !(st.wr_pend && st.wr_addr == gpio_wake_pkg::STATUS_ADDR)
		|=> st.event_flag)
		else $error("wake event dropped");
endmodule
`default_nettype wire

// ### test/host_wake_model.sv
// Host wake logic and board LED pull-ups on the far side of the block
`timescale 1ns/100ps
`default_nettype none
module host_wake_model (
	input  wire logic                      mclk,          // Block clock
	input  wire gpio_wake_pkg::pin_drive_t drive,         // GPIO/LED pin drive
	input  wire logic                      wake_out,      // Wake pin value
	input  wire logic                      wake_oe,       // Wake pin enable
	output logic      [2:0]                pin_level,     // Board level of each pin
	output logic                           wake_level,    // Board level of wake net
	output logic                           host_select_n, // Host chip select
	output logic                           host_write_n   // Host write strobe
);
	// Released nets rest at the board pull-up, never at the last driven value
	assign pin_level  = drive.out | ~drive.oe;
	assign wake_level = wake_oe ? wake_out : 1'b1;
	initial begin
		host_select_n = 1'b1;
		host_write_n  = 1'b1;
	end
	// One host bus cycle; strobes held for one clock, no address is driven
	task automatic host_cycle(input logic sel, input logic wr);
		@(posedge mclk);
		host_select_n <= ~sel;
		host_write_n  <= ~wr;
		@(posedge mclk);
		host_select_n <= 1'b1;
		host_write_n  <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ### test/led_gpio_wake_indicator_tb_top.sv
// Self-checking bench for the LED, GPIO and wake block
`timescale 1ns/100ps
`default_nettype none
module led_gpio_wake_indicator_tb_top;
	localparam int BL = 20;                      // Short blink time keeps runs brief
	logic                        mclk, rst_n, hsel, hwrite, hreadyout, hresp, rd_dp;
	logic                        wake_event, speed_sel, wake_out, wake_oe, sleeping;
	logic                        speed_default, host_select_n, host_write_n, wake_level;
	logic [7:0]                  haddr;
	logic [1:0]                  htrans;
	logic [2:0]                  hsize, gpio_in, pin_level, dir, od, dv, ex;
	logic [31:0]                 hwdata, hrdata, r;
	logic [31:0]                 rd_q[$];        // Expected read data, oldest first
	gpio_wake_pkg::link_status_t link;
	gpio_wake_pkg::pin_drive_t   drive;
	int                          error_cnt, n_tests, seed, hi, lo;

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	led_gpio_wake_indicator #(.BLINK_CYCLES(BL)) DUT (.MCLK(mclk), .RST_N(rst_n),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
		.HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
		.HRESP(hresp), .LINK(link), .WAKE_EVENT(wake_event),
		.HOST_SELECT_N(host_select_n), .HOST_WRITE_N(host_write_n),
		.SPEED_SEL(speed_sel), .GPIO_IN(gpio_in), .GPIO_DRIVE(drive),
		.WAKE_OUT(wake_out), .WAKE_OE(wake_oe), .SLEEPING(sleeping),
		.SPEED_DEFAULT(speed_default));

	host_wake_model partner (.mclk(mclk), .drive(drive), .wake_out(wake_out),
		.wake_oe(wake_oe), .pin_level(pin_level), .wake_level(wake_level),
		.host_select_n(host_select_n), .host_write_n(host_write_n));

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	endtask

	// Bounded wait for the slave's ready at a rising edge
	task automatic wait_rdy();
		int k;
		k = 0;
		@(posedge mclk);
		while (hreadyout !== 1'b1 && k < 16) begin
			@(posedge mclk);
			k++;
		end
		if (k == 16) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask

	// Single word transfer: address phase held until ready, then data phase
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge mclk);
		hsel   <= 1'b1;
		htrans <= gpio_wake_pkg::HTRANS_NONSEQ;
		haddr  <= a;
		hwrite <= w;
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		ahb(a, 1'b0, 32'h0000_0000);
	endtask

	// Outputs follow register changes a couple of edges later
	task automatic settle();
		repeat (3) @(posedge mclk);
		#1;
	endtask

	task automatic pulse();
		@(posedge mclk);
		wake_event <= 1'b1;
		@(posedge mclk);
		wake_event <= 1'b0;
	endtask

	// Length of the current run of the link LED level, capped
	task automatic run_len(input logic v, output int n);
		n = 0;
		while (pin_level[1] === v && n < 4 * BL) begin
			@(posedge mclk);
			n++;
		end
	endtask

	// Data phase watcher: each read result is matched to the oldest note
	always @(posedge mclk) begin
		if (rd_dp && hreadyout === 1'b1 && rd_q.size() > 0) begin
			check(hrdata === rd_q.pop_front(), "read data");
			check(hresp === 1'b0, "response not OKAY");
		end
		if (hreadyout === 1'b1)
			rd_dp <= hsel && htrans == gpio_wake_pkg::HTRANS_NONSEQ && !hwrite;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		seed = 9928;
		error_cnt = 0;
		n_tests = 0;
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		link = '0;
		wake_event = 1'b0;
		speed_sel = 1'b1;
		gpio_in = 3'h0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		speed_sel <= 1'b0;
		settle();
		check(speed_default === 1'b1, "strap not latched");
		check(pin_level === 3'h7 && wake_oe === 1'b0, "reset drive");
		rd(gpio_wake_pkg::STATUS_ADDR, 32'h0000_0004);
		rd(8'h10, 32'h0000_0000);
		// Random direction, drive type and data per pin
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			{dv, od, dir} = r[8:0];
			@(posedge mclk);
			gpio_in <= r[11:9];
			ahb(gpio_wake_pkg::PIN_CFG_ADDR, 1'b1, {25'h0, od, 1'b0, dir});
			ahb(gpio_wake_pkg::PIN_DATA_ADDR, 1'b1, {29'h0, dv});
			settle();
			check(pin_level === (dv | ~dir), "gpio level");
			check((drive.oe & dir & ~od) === (dir & ~od), "push-pull enable");
			rd(gpio_wake_pkg::PIN_DATA_ADDR, {29'h0, r[11:9]});
		end
		// LED function on all pins, push-pull setting must not matter
		ahb(gpio_wake_pkg::PIN_CFG_ADDR, 1'b1, 32'h0000_0707);
		for (int c = 0; c < 16; c++) begin
			@(posedge mclk);
			link <= {c[3:0], 1'b0};
			settle();
			ex = {~(c[3] & c[0]), ~c[3], c[3] & c[2] & ~c[1]};
			check(pin_level === ex, "LED levels");
			check((drive.out & drive.oe) === 3'h0, "LED driven high");
		end
		// Activity held: off pulse, on hold, repeat
		@(posedge mclk);
		link <= 5'b10001;
		run_len(1'b0, lo);
		run_len(1'b1, hi);
		run_len(1'b0, lo);
		check(hi == BL && lo >= BL, "activity blink");
		@(posedge mclk);
		link <= 5'b10000;
		run_len(1'b1, hi);
		run_len(1'b0, lo);
		check(hi == BL - 1 && lo == 4 * BL, "blink end");
		// Sleep exit only on a host write cycle
		ahb(gpio_wake_pkg::WAKE_CTRL_ADDR, 1'b1, 32'h0000_0008);
		pulse();
		settle();
		check(sleeping === 1'b1, "event woke device");
		partner.host_cycle(1'b1, 1'b0);
		settle();
		check(sleeping === 1'b1, "select alone woke device");
		partner.host_cycle(1'b1, 1'b1);
		settle();
		check(sleeping === 1'b0, "host write did not wake");
		rd(gpio_wake_pkg::STATUS_ADDR, 32'h0000_0005);
		ahb(gpio_wake_pkg::STATUS_ADDR, 1'b1, 32'h0000_0001);
		// Every polarity and drive type of the wake pin
		for (int m = 0; m < 4; m++) begin
			ahb(gpio_wake_pkg::WAKE_CTRL_ADDR, 1'b1, {29'h0, m[1:0], 1'b1});
			settle();
			check(wake_level === ~m[0], "wake idle level");
			pulse();
			settle();
			check(wake_level === m[0], "wake asserted level");
			check(m[1] ? wake_oe === 1'b1 : wake_out === 1'b0, "wake drive");
			rd(gpio_wake_pkg::STATUS_ADDR, 32'h0000_0005);
			ahb(gpio_wake_pkg::STATUS_ADDR, 1'b1, 32'h0000_0001);
			settle();
			check(wake_level === ~m[0], "wake after clear");
			pulse();
			ahb(gpio_wake_pkg::WAKE_CTRL_ADDR, 1'b1, {29'h0, m[1:0], 1'b0});
			settle();
			check(wake_level === ~m[0], "wake after disable");
			ahb(gpio_wake_pkg::STATUS_ADDR, 1'b1, 32'h0000_0001);
		end
		settle();
		tally_and_finish();
	end
endmodule
`default_nettype wire
